/* File: logic/amsp_panel.sv */
// Behaviour
// - mode button advances candidate, mode unchanged
// - dot lit for enterable candidate, dark if active
// - enter commits mode, dot off, submenu 1s
// - no enter in 2s: flash name 1s
// - active mode holds until new commit
// - setup modes offered only when unlocked
// - error mode offered only with system error
// - valid passcode is 3282
// - passcode: name 1s, then zeros, first blinks
// - knob steps digit, enter accepts, next blinks
// - valid code unlocks, or fault-lock on sensors
// - four enters unchanged relock, show locked
// - any wrong code locks unit
// - manual: name 1s, then raw shaft degrees
// - full turn uncalibrated, limits once calibrated
// - manual dot blinks faster with motor speed
// - auto: position from scaled loop current
// - feedback current linear with percent open
// - auto enter cycles four status items
// - knob toggles temperature unit C/F on temperature items only
// - percent open from main shaft sensor
// - loop input accepts either polarity
`timescale 1ns/1ps
`default_nettype none
module amsp_panel
  import amsp_pkg::*;
#(
  parameter int unsigned ADC_W   = 12,
  parameter int unsigned SPEED_W = 8,
  parameter int unsigned TMR_W   = 25,
  parameter int unsigned TIME_DIV = 1  // divides the browse, commit and name timer lengths; 1 keeps real time
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // operator keys, one-cycle pulses
  input  wire amsp_keys_t         keys,
  // system conditions
  input  wire logic               sysError,
  input  wire logic               bothSensorsFailed,
  input  wire logic               calibrated,
  // shaft and motor
  input  wire logic [8:0]         shaftDeg,
  input  wire logic [8:0]         limitLowDeg,
  input  wire logic [8:0]         limitHighDeg,
  input  wire logic               motorRunning,
  input  wire logic [SPEED_W-1:0] motorSpeed,
  // loop current, differential, signed
  input  wire logic signed [ADC_W:0] loopCurrent,
  input  wire logic [ADC_W-1:0]   loopCalLow,
  input  wire logic [ADC_W-1:0]   loopCalHigh,
  input  wire logic [6:0]         percentOpen,
  // display
  output amsp_disp_t              disp,
  // actuation
  output amsp_mode_t              activeMode,
  output logic                    unlocked,
  output logic                    jogUp,
  output logic                    jogDown,
  output logic [6:0]              positionCmd,
  output logic [ADC_W-1:0]        feedbackOut
);

  initial begin
    if (ADC_W < 8 || ADC_W > 16) $error("amsp_panel: bad ADC_W");
    if (TMR_W < $clog2(BROWSE_CYC + 1)) $error("amsp_panel: TMR_W too small");
    if (TIME_DIV < 1 || NAME_CYC / TIME_DIV < 2) $error("amsp_panel: bad TIME_DIV");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic mode_offered(input logic [3:0] m, input logic unl,
                                        input logic err);
    if (m == MD_ERROR) return err;
    if (m >= MD_USER) return unl;
    return 1'b1;
  endfunction

  function automatic logic [3:0] next_candidate(input logic [3:0] m, input logic unl,
                                                input logic err);
    logic [3:0] c;
    c = m;
    for (int i = 0; i < 12; i++) begin
      c = (c == MODE_LAST) ? 4'h0 : c + 4'h1;
      if (mode_offered(c, unl, err)) return c;
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    PS_SUBMENU = 6'b00_0001,
    PS_BROWSE  = 6'b00_0010,
    PS_COMMIT  = 6'b00_0100,
    PS_FLASH   = 6'b00_1000,
    PS_DIGITS  = 6'b01_0000,
    PS_RESULT  = 6'b10_0000
  } amsp_pst_t;

  typedef struct packed {
    amsp_pst_t   phase;
    amsp_mode_t  mode;
    amsp_mode_t  cand;
    logic        unl;
    logic        nameShown;
    logic [15:0] code;
    logic [1:0]  pos;
    logic        touched;
    amsp_ind_t   ind;
    amsp_stat_t  item;
    logic        fahr;
    logic [6:0]  posCmd;
    logic [ADC_W-1:0] fbOut;
  } amsp_state_t;

  amsp_state_t state_ff;
  amsp_state_t nxt_state;

  logic             tmrLoad;
  logic [TMR_W-1:0] tmrValue;
  logic             tmrExpired;
  logic             tmrRunning;
  logic             dotBlink;

  amsp_timer #(.WIDTH(TMR_W)) u_timer (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .load      (tmrLoad),
    .loadValue (tmrValue),
    .expired   (tmrExpired),
    .running   (tmrRunning)
  );

  amsp_rate_blink #(.SPEED_W(SPEED_W)) u_blink (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .motorRunning (motorRunning && (state_ff.mode == MD_USER)),
    .motorSpeed   (motorSpeed),
    .dotBlink     (dotBlink)
  );

  // loop magnitude, polarity ignored
  logic [ADC_W-1:0] loopMag;
  logic [ADC_W+7:0] scaled;
  logic [ADC_W-1:0] span;
  assign loopMag = loopCurrent[ADC_W] ? ADC_W'(-loopCurrent) : loopCurrent[ADC_W-1:0];
  assign span    = (loopCalHigh > loopCalLow) ? loopCalHigh - loopCalLow : {{(ADC_W-1){1'b0}}, 1'b1};
  assign scaled  = (loopMag <= loopCalLow) ? '0 :
                   (ADC_W+8)'(((ADC_W+8)'(loopMag - loopCalLow) * (ADC_W+8)'(100)) / span);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] dig;
    dig       = 4'h0;
    nxt_state = state_ff;
    tmrLoad   = 1'b0;
    tmrValue  = '0;
    unique case (state_ff.phase)
      PS_SUBMENU: begin
        if (keys.modeBtn) begin
          nxt_state.cand  = amsp_mode_t'(next_candidate(state_ff.mode, state_ff.unl,
                                                         sysError));
          nxt_state.phase = PS_BROWSE;
          tmrLoad         = 1'b1;
          tmrValue        = TMR_W'(BROWSE_CYC / TIME_DIV);
        end else if (keys.enterBtn && state_ff.mode == MD_AUTO) begin
          nxt_state.item  = amsp_stat_t'(state_ff.item + 2'h1);
        end else if ((keys.knobUp || keys.knobDown) && state_ff.mode == MD_AUTO
                     && (state_ff.item == ST_TEMP_ACT || state_ff.item == ST_TEMP_MAX)) begin
          nxt_state.fahr  = !state_ff.fahr;
        end
        if (tmrExpired || !tmrRunning) nxt_state.nameShown = 1'b0;
      end
      PS_BROWSE: begin
        if (keys.modeBtn) begin
          nxt_state.cand = amsp_mode_t'(next_candidate(state_ff.cand, state_ff.unl,
                                                        sysError));
          tmrLoad        = 1'b1;
          tmrValue       = TMR_W'(BROWSE_CYC / TIME_DIV);
        end else if (keys.enterBtn) begin
          nxt_state.mode  = state_ff.cand;
          nxt_state.phase = PS_COMMIT;
          tmrLoad         = 1'b1;
          tmrValue        = TMR_W'(COMMIT_CYC / TIME_DIV);
        end else if (tmrExpired) begin
          nxt_state.phase = PS_FLASH;
          tmrLoad         = 1'b1;
          tmrValue        = TMR_W'(NAME_CYC / TIME_DIV);
        end
      end
      PS_COMMIT: begin
        if (tmrExpired) begin
          nxt_state.nameShown = 1'b1;
          nxt_state.item      = ST_PCT_OPEN;
          nxt_state.code      = 16'h0000;
          nxt_state.pos       = 2'h0;
          nxt_state.touched   = 1'b0;
          tmrLoad             = 1'b1;
          tmrValue            = TMR_W'(NAME_CYC / TIME_DIV);
          nxt_state.phase     = (state_ff.mode == MD_PASS) ? PS_DIGITS : PS_SUBMENU;
        end
      end
      PS_FLASH: begin
        if (tmrExpired) nxt_state.phase = PS_SUBMENU;
      end
      PS_DIGITS: begin
        if (tmrExpired) nxt_state.nameShown = 1'b0;
        if (!state_ff.nameShown) begin
          dig = state_ff.code[4*(3-state_ff.pos) +: 4];
          if (keys.knobUp) begin
            dig = (dig == DIGIT_MAX) ? 4'h0 : dig + 4'h1;
            nxt_state.touched = 1'b1;
          end else if (keys.knobDown) begin
            dig = (dig == 4'h0) ? DIGIT_MAX : dig - 4'h1;
            nxt_state.touched = 1'b1;
          end
          nxt_state.code[4*(3-state_ff.pos) +: 4] = dig;
          if (keys.enterBtn) begin
            if (state_ff.pos == LAST_DIGIT) begin
              nxt_state.phase = PS_RESULT;
              if (state_ff.code == PASS_CODE) begin
                nxt_state.unl = !bothSensorsFailed;
                nxt_state.ind = bothSensorsFailed ? IND_FAULT : IND_UNLOCKED;
              end else begin
                nxt_state.unl = 1'b0;
                nxt_state.ind = IND_LOCKED;
              end
            end else begin
              nxt_state.pos = state_ff.pos + 2'h1;
            end
          end
        end
      end
      PS_RESULT: begin
        if (keys.modeBtn) begin
          nxt_state.cand  = amsp_mode_t'(next_candidate(state_ff.mode, state_ff.unl,
                                                         sysError));
          nxt_state.phase = PS_BROWSE;
          tmrLoad         = 1'b1;
          tmrValue        = TMR_W'(BROWSE_CYC / TIME_DIV);
        end
      end
    endcase
    // automatic position from the loop, and feedback from percent open
    if (state_ff.mode == MD_AUTO) begin
      nxt_state.posCmd = (scaled > 20'd100) ? 7'd100 : scaled[6:0];
    end
    nxt_state.fbOut = ADC_W'(((ADC_W+8)'(percentOpen) * (ADC_W+8)'({ADC_W{1'b1}})) / 100);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff       <= '0;
      state_ff.phase <= PS_SUBMENU;
      state_ff.mode  <= MD_AUTO;
      state_ff.cand  <= MD_AUTO;
      state_ff.unl   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic inUser;
  assign inUser = (state_ff.mode == MD_USER) && (state_ff.phase == PS_SUBMENU)
                  && !state_ff.nameShown;
  assign jogUp   = inUser && keys.knobUp &&
                   (!calibrated || shaftDeg < limitHighDeg) &&
                   (calibrated || shaftDeg < FULL_TURN_DEG);
  assign jogDown = inUser && keys.knobDown && (!calibrated || shaftDeg > limitLowDeg);

  always_comb begin
    disp            = '0;
    disp.modeCode   = state_ff.mode;
    disp.statusItem = state_ff.item;
    disp.fahrenheit = state_ff.fahr;
    disp.indication = state_ff.ind;
    disp.digits     = state_ff.code;
    unique case (state_ff.phase)
      PS_BROWSE: begin
        disp.show     = SH_CANDIDATE;
        disp.modeCode = state_ff.cand;
        disp.rightDot = (state_ff.cand != state_ff.mode);
      end
      PS_COMMIT, PS_FLASH: begin
        disp.show = SH_MODE_NAME;
      end
      PS_DIGITS: begin
        disp.show = state_ff.nameShown ? SH_MODE_NAME : SH_DIGITS;
        disp.blinkDigit = state_ff.nameShown ? 4'h0 : 4'b1000 >> state_ff.pos;
      end
      PS_RESULT: disp.show = SH_INDICATE;
      PS_SUBMENU: begin
        if (state_ff.nameShown) begin
          disp.show = SH_MODE_NAME;
        end else if (state_ff.mode == MD_USER) begin
          disp.show     = SH_SHAFT;
          disp.digits   = {7'h00, shaftDeg};
          disp.rightDot = dotBlink;
        end else if (state_ff.mode == MD_AUTO) begin
          disp.show   = SH_STATUS;
          disp.digits = {9'h000, percentOpen};
        end else begin
          disp.show = SH_MODE_NAME;
        end
      end
    endcase
  end

  assign activeMode  = state_ff.mode;
  assign unlocked    = state_ff.unl;
  assign positionCmd = state_ff.posCmd;
  assign feedbackOut = state_ff.fbOut;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_browse_keeps_mode: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff.phase == PS_BROWSE && keys.modeBtn) |=> $stable(state_ff.mode))
    else $error("mode changed while browsing");
  a_dot_active_dark: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff.phase == PS_BROWSE && state_ff.cand == state_ff.mode) |-> !disp.rightDot)
    else $error("dot lit on active mode");
  a_commit_takes_cand: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff.phase == PS_BROWSE && keys.enterBtn && !keys.modeBtn)
    |=> (state_ff.mode == $past(state_ff.cand)) && !disp.rightDot)
    else $error("commit did not take candidate");
  a_flash_keeps_mode: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff.phase == PS_FLASH) |=> $stable(state_ff.mode))
    else $error("mode changed during flash");
  a_setup_needs_unlock: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff.phase == PS_BROWSE && !state_ff.unl) |->
    !(state_ff.cand inside {MD_USER, MD_CAL, MD_BKCAL, MD_SETUP, MD_OVERRIDE}))
    else $error("setup mode offered while locked");
  a_error_needs_fault: assert property (@(posedge sys_clk) disable iff (reset)
    (keys.modeBtn && !sysError && state_ff.phase != PS_DIGITS
     && state_ff.phase != PS_COMMIT && state_ff.phase != PS_FLASH)
    |=> state_ff.cand != MD_ERROR)
    else $error("error mode offered without fault");
  a_good_code_unlocks: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff.phase == PS_DIGITS && !state_ff.nameShown && keys.enterBtn && !keys.knobUp
     && !keys.knobDown && state_ff.pos == LAST_DIGIT && state_ff.code == PASS_CODE)
    |=> (state_ff.unl == !$past(bothSensorsFailed)))
    else $error("valid code did not unlock");
  a_bad_code_locks: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff.phase == PS_DIGITS && !state_ff.nameShown && keys.enterBtn
     && state_ff.pos == LAST_DIGIT && state_ff.code != PASS_CODE)
    |=> !state_ff.unl && state_ff.ind == IND_LOCKED)
    else $error("wrong code did not lock");
  a_plain_enters_lock: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff.phase == PS_DIGITS && !state_ff.nameShown && keys.enterBtn
     && state_ff.pos == LAST_DIGIT && !state_ff.touched)
    |=> !state_ff.unl && state_ff.ind == IND_LOCKED)
    else $error("plain enters did not relock");
  a_jog_within_limits: assert property (@(posedge sys_clk) disable iff (reset)
    (calibrated && shaftDeg >= limitHighDeg) |-> !jogUp)
    else $error("jog past calibrated limit");

endmodule // amsp_panel
`default_nettype wire

/* File: logic/amsp_pkg.sv */
package amsp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned COMMIT_MS     = 1000;
  localparam int unsigned BROWSE_MS     = 2000;
  localparam int unsigned NAME_MS       = 1000;
  localparam int unsigned COMMIT_CYC    = CLK_HZ / 1000 * COMMIT_MS;
  localparam int unsigned BROWSE_CYC    = CLK_HZ / 1000 * BROWSE_MS;
  localparam int unsigned NAME_CYC      = CLK_HZ / 1000 * NAME_MS;
  localparam int unsigned BLINK_CYC     = CLK_HZ / 4;

  // ----------------------------------------------------------------
  // passcode and ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] PASS_CODE     = 16'h3282;
  localparam logic [8:0]  FULL_TURN_DEG = 9'h168;
  localparam logic [3:0]  DIGIT_MAX     = 4'h9;
  localparam logic [1:0]  LAST_DIGIT    = 2'h3;

  // ----------------------------------------------------------------
  // modes, display items and indications
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MD_AUTO     = 4'h0,
    MD_FBPOS    = 4'h1,
    MD_FB2ST    = 4'h2,
    MD_DISCRETE_OPEN_CLOSE_MODE     = 4'h3,
    MD_TOGGLE   = 4'h4,
    MD_PASS     = 4'h5,
    MD_USER     = 4'h6,
    MD_CAL      = 4'h7,
    MD_BKCAL    = 4'h8,
    MD_SETUP    = 4'h9,
    MD_OVERRIDE = 4'hA,
    MD_ERROR    = 4'hB
  } amsp_mode_t;
  localparam logic [3:0] MODE_LAST = 4'hB;

  typedef enum logic [2:0] {
    SH_MODE_NAME = 3'h0,
    SH_CANDIDATE = 3'h1,
    SH_DIGITS    = 3'h2,
    SH_INDICATE  = 3'h3,
    SH_SHAFT     = 3'h4,
    SH_STATUS    = 3'h5
  } amsp_show_t;

  typedef enum logic [1:0] {
    IND_NONE     = 2'h0,
    IND_UNLOCKED = 2'h1,
    IND_FAULT    = 2'h2,
    IND_LOCKED   = 2'h3
  } amsp_ind_t;

  typedef enum logic [1:0] {
    ST_PCT_OPEN = 2'h0,
    ST_TEMP_ACT = 2'h1,
    ST_TEMP_MAX = 2'h2,
    ST_CYCLES   = 2'h3
  } amsp_stat_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic modeBtn;
    logic enterBtn;
    logic knobUp;
    logic knobDown;
  } amsp_keys_t;

  typedef struct packed {
    amsp_show_t     show;
    amsp_mode_t     modeCode;
    amsp_ind_t      indication;
    amsp_stat_t     statusItem;
    logic           fahrenheit;
    logic [15:0]    digits;
    logic [3:0]     blinkDigit;
    logic           rightDot;
  } amsp_disp_t;

endpackage : amsp_pkg

/* File: logic/amsp_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module amsp_timer
  import amsp_pkg::*;
#(
  parameter int unsigned WIDTH = 25
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadValue,
  // status
  output logic                  expired,
  output logic                  running
);

  initial begin
    if (WIDTH < 2) $error("amsp_timer: WIDTH too small");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } amsp_tmr_t;

  amsp_tmr_t state_ff;
  amsp_tmr_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (load) begin
      nxt_state.count = loadValue;
    end else if (state_ff.count != '0) begin
      nxt_state.count = state_ff.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // expiry is a one-cycle pulse on the last count
  assign expired = (state_ff.count == {{(WIDTH-1){1'b0}}, 1'b1});
  assign running = (state_ff.count != '0);

endmodule // amsp_timer
`default_nettype wire

/* File: logic/amsp_rate_blink.sv */
`timescale 1ns/1ps
`default_nettype none
module amsp_rate_blink
  import amsp_pkg::*;
#(
  parameter int unsigned SPEED_W = 8
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // motor
  input  wire logic               motorRunning,
  input  wire logic [SPEED_W-1:0] motorSpeed,
  // indicator
  output logic                    dotBlink
);

  initial begin
    if (SPEED_W < 1 || SPEED_W > 16) $error("amsp_rate_blink: bad SPEED_W");
  end

  typedef struct packed {
    logic [24:0] phase;
    logic        dot;
  } amsp_blk_t;

  amsp_blk_t state_ff;
  amsp_blk_t nxt_state;
  logic [24:0] step;

  // the phase advances faster with speed, so the blink rate tracks the motor
  assign step = 25'(motorSpeed) + 25'h000_0001;

  always_comb begin
    nxt_state = state_ff;
    if (!motorRunning) begin
      nxt_state.phase = '0;
      nxt_state.dot   = 1'b0;
    end else if (state_ff.phase + step >= 25'(BLINK_CYC)) begin
      nxt_state.phase = '0;
      nxt_state.dot   = !state_ff.dot;
    end else begin
      nxt_state.phase = state_ff.phase + step;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign dotBlink = state_ff.dot;

endmodule // amsp_rate_blink
`default_nettype wire

/* File: bench/amsp_operator.sv */
`timescale 1ns/1ps
`default_nettype none
module amsp_operator
  import amsp_pkg::*;
(
  // clock
  input  wire logic sys_clk,
  // keys, one-cycle pulses
  output amsp_keys_t keys
);
  initial keys = '0;
  // one key at a time; an idle cycle always follows a press
  task automatic press(input amsp_keys_t k);
    @(posedge sys_clk);
    #10 keys = k;
    @(posedge sys_clk);
    #10 keys = '0;
  endtask
endmodule // amsp_operator
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_top
  import amsp_pkg::*;
;
  localparam amsp_keys_t K_MODE = 4'h8;
  localparam amsp_keys_t K_ENT  = 4'h4;
  localparam amsp_keys_t K_UP   = 4'h2;
  localparam amsp_keys_t K_DN   = 4'h1;
  logic              sys_clk = 1'b0;
  logic              reset = 1'b1;
  amsp_keys_t        keys;
  logic              sysError = 1'b0;
  logic              bothSensorsFailed = 1'b0;
  logic              calibrated = 1'b0;
  logic [8:0]        shaftDeg = 9'h05A;
  logic [8:0]        limitLowDeg = 9'h000;
  logic [8:0]        limitHighDeg = 9'h05A;
  logic              motorRunning = 1'b0;
  logic [7:0]        motorSpeed = 8'h00;
  logic signed [12:0] loopCurrent = 13'sh0320;
  logic [11:0]       loopCalLow = 12'h320;
  logic [11:0]       loopCalHigh = 12'hFA0;
  logic [6:0]        percentOpen = 7'h00;
  amsp_disp_t        disp;
  amsp_mode_t        activeMode;
  logic              unlocked;
  logic [6:0]        positionCmd;
  logic [11:0]       feedbackOut;
  logic              jogUp;
  logic              jogDown;
  int                nUp = 0;
  int                nDn = 0;
  int                n_fail = 0;
  int                n_tests = 0;
  int                cycles = 0;

  always #50 sys_clk = ~sys_clk;

  amsp_operator op (.sys_clk(sys_clk), .keys(keys));

  // timers scaled down so commit and name phases last 500 cycles and browse 1000
  amsp_panel #(.TIME_DIV(20000)) uut (
    .sys_clk(sys_clk), .reset(reset), .keys(keys), .sysError(sysError),
    .bothSensorsFailed(bothSensorsFailed), .calibrated(calibrated),
    .shaftDeg(shaftDeg), .limitLowDeg(limitLowDeg), .limitHighDeg(limitHighDeg),
    .motorRunning(motorRunning), .motorSpeed(motorSpeed), .loopCurrent(loopCurrent),
    .loopCalLow(loopCalLow), .loopCalHigh(loopCalHigh), .percentOpen(percentOpen),
    .disp(disp), .activeMode(activeMode), .unlocked(unlocked), .jogUp(jogUp), .jogDown(jogDown),
    .positionCmd(positionCmd), .feedbackOut(feedbackOut));

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    `CHK("active mode", MD_AUTO, activeMode)
    `CHK("unlocked", 1'b0, unlocked)
    `CHK("show", SH_STATUS, disp.show)
  endtask

  task automatic t_status();
    op.press(K_UP);
    `CHK("unit on item 0", 1'b0, disp.fahrenheit)
    for (int i = 1; i <= 4; i++) begin
      op.press(K_ENT);
      `CHK("status item", 2'(i), disp.statusItem)
    end
    op.press(K_ENT);
    op.press(K_UP);
    `CHK("unit up", 1'b1, disp.fahrenheit)
    op.press(K_DN);
    `CHK("unit down", 1'b0, disp.fahrenheit)
    repeat (3) op.press(K_ENT);
    `CHK("no jog in auto", 0, nUp + nDn)
  endtask

  task automatic t_feedback();
    for (int p = 0; p <= 100; p += 50) begin
      percentOpen = 7'(p);
      repeat (3) @(posedge sys_clk);
      #10;
      `CHK("feedback", 12'(p * 4095 / 100), feedbackOut)
    end
  endtask

  // either polarity of the loop gives the same command
  task automatic t_loop();
    logic signed [12:0] v[4] = '{13'sh0FA0, -13'sh0FA0, 13'sh0320, -13'sh0320};
    for (int i = 0; i < 4; i++) begin
      loopCurrent = v[i];
      repeat (3) @(posedge sys_clk);
      #10;
      `CHK("position cmd", (i < 2) ? 7'h64 : 7'h00, positionCmd)
    end
  endtask

  task automatic t_browse(input logic err);
    logic [3:0] e;
    sysError = err;
    e = 4'h0;
    do begin
      e = (e == 4'h5) ? (err ? 4'hB : 4'h0) : ((e == 4'hB) ? 4'h0 : e + 4'h1);
      op.press(K_MODE);
      `CHK("candidate", e, disp.modeCode)
      `CHK("show", SH_CANDIDATE, disp.show)
      `CHK("browse dot", e != 4'h0, disp.rightDot)
      `CHK("mode held", MD_AUTO, activeMode)
    end while (e != 4'h0);
  endtask

  task automatic t_commit();
    repeat (2) op.press(K_MODE);
    op.press(K_ENT);
    `CHK("committed", MD_FB2ST, activeMode)
    `CHK("dot off", 1'b0, disp.rightDot)
    `CHK("name shown", SH_MODE_NAME, disp.show)
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask

  task automatic go_mode(input int n, input logic ent);
    repeat (n) op.press(K_MODE);
    if (ent) op.press(K_ENT);
  endtask

  // steps each digit the short way round, so an 8 wraps down through 9
  task automatic enter_code(input logic [15:0] c);
    logic [3:0] d;
    for (int i = 3; i >= 0; i--) begin
      d = c[4*i +: 4];
      `CHK("blink digit", 4'(1 << i), disp.blinkDigit)
      if (d <= 4'h5) repeat (d) op.press(K_UP);
      else repeat (10 - d) op.press(K_DN);
      `CHK("digit", d, disp.digits[4*i +: 4])
      op.press(K_ENT);
    end
  endtask

  task automatic t_pass();
    sysError = 1'b0;
    wait_cyc(1050);
    go_mode(3, 1'b0);
    `CHK("browse pass", MD_PASS, disp.modeCode)
    wait_cyc(900);
    `CHK("still browsing", SH_CANDIDATE, disp.show)
    wait_cyc(150);
    `CHK("flash", SH_MODE_NAME, disp.show)
    `CHK("flash name", MD_FB2ST, disp.modeCode)
    wait_cyc(500);
    `CHK("mode kept", MD_FB2ST, activeMode)
    go_mode(3, 1'b1);
    `CHK("pass committed", MD_PASS, activeMode)
    wait_cyc(950);
    `CHK("pass name", SH_MODE_NAME, disp.show)
    wait_cyc(100);
    `CHK("show digits", SH_DIGITS, disp.show)
    `CHK("zeros", 16'h0000, disp.digits)
    enter_code(16'h3282);
    `CHK("unlocked", 1'b1, unlocked)
    `CHK("unlock shown", IND_UNLOCKED, disp.indication)
  endtask

  task automatic t_manual();
    go_mode(1, 1'b0);
    `CHK("setup offered", MD_USER, disp.modeCode)
    op.press(K_ENT);
    wait_cyc(950);
    `CHK("manual name", SH_MODE_NAME, disp.show)
    wait_cyc(100);
    `CHK("shaft shown", SH_SHAFT, disp.show)
    `CHK("shaft deg", 16'h005A, disp.digits)
    op.press(K_UP);
    op.press(K_DN);
    calibrated = 1'b1;
    op.press(K_UP);
    `CHK("jog up", 1, nUp)
    `CHK("jog down", 1, nDn)
    motorSpeed = 8'hFF;
    motorRunning = 1'b1;
    wait_cyc(10000);
    `CHK("dot blink", 1'b1, disp.rightDot)
    motorRunning = 1'b0;
  endtask

  task automatic t_relock();
    go_mode(10, 1'b1);
    wait_cyc(1050);
    repeat (4) op.press(K_ENT);
    `CHK("relocked", 1'b0, unlocked)
    `CHK("locked shown", IND_LOCKED, disp.indication)
    `CHK("show ind", SH_INDICATE, disp.show)
  endtask

  task automatic t_fault();
    bothSensorsFailed = 1'b1;
    go_mode(6, 1'b1);
    wait_cyc(1050);
    enter_code(16'h3282);
    `CHK("fault lock", IND_FAULT, disp.indication)
    `CHK("stays locked", 1'b0, unlocked)
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // jog pulses stand only while the knob key stands, so count them at the edge
  always @(posedge sys_clk) begin
    nUp += jogUp;
    nDn += jogDown;
  end

  // a hang costs at most this many cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    #10 reset = 1'b0;
    t_reset();
    t_status();
    t_feedback();
    t_loop();
    t_browse(1'b0);
    t_browse(1'b1);
    t_commit();
    t_pass();
    t_manual();
    t_relock();
    t_fault();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
